// file: core_ack_model.sv
// Core side model that acknowledges what is pending
`default_nettype none
module core_ack_model (
  input wire logic clk, reset_n, int_pending, nmi_pending,
  output var logic ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack_d;
  // Spaced acks, so a stale pending never gets a second one
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'h0;
      ack_d <= 1'h0;
    end else begin
      ack <= (int_pending || nmi_pending) && !ack && !ack_d;
      ack_d <= ack;
    end
  end
endmodule
`default_nettype wire

// file: edge_fall_detect.v
// Synchroniser and falling edge detector for a group of pins
`default_nettype none
module edge_fall_detect #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] pins,
  output reg fall
);
  reg [WIDTH-1:0] sync1;
  reg [WIDTH-1:0] sync2;
  reg [WIDTH-1:0] prev;
  // ==========================================
  // Two stages, then edge compare on settled copy only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= {WIDTH{1'b1}};
      sync2 <= {WIDTH{1'b1}};
      prev <= {WIDTH{1'b1}};
      fall <= 1'b0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      prev <= sync2;
      fall <= |(prev & ~sync2);
    end
  end
endmodule
`default_nettype wire

// file: intc_checker.sv
// Assertion checker for the interrupt and test input logic
`default_nettype none
module intc_checker #(parameter NSRC = 19) (
  input wire logic clk, reset_n, timer8_a_match_req, conversion_done_req, software_break_insn,
  input wire logic watchdog_overflow_req, watchdog_mode_sel, watch_overflow_test, ack,
  input wire logic int_pending, nmi_pending, test_wake,
  input wire logic [1:0] test_mask_flag, test_flag,
  input wire logic [NSRC-1:0] request_flag,
  input wire logic [15:0] int_vector
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_tma; timer8_a_match_req |=> request_flag[16]; endproperty
  a_tma: assert property (p_tma) else $error("timer flag");
  property p_ad; conversion_done_req |=> request_flag[18]; endproperty
  a_ad: assert property (p_ad) else $error("conv flag");
  property p_brk; software_break_insn |=> int_pending && int_vector == 16'h003E; endproperty
  a_brk: assert property (p_brk) else $error("break");
  property p_nmi; watchdog_overflow_req && watchdog_mode_sel |=> nmi_pending; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi");
  property p_nmih; nmi_pending && !ack |=> nmi_pending; endproperty
  a_nmih: assert property (p_nmih) else $error("nmi drop");
  property p_vec; int_pending |-> !int_vector[0] && int_vector >= 16'h0004 && int_vector <= 16'h003E; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_wt; watch_overflow_test |=> test_flag[0]; endproperty
  a_wt: assert property (p_wt) else $error("watch");
  property p_msk; (test_mask_flag == 2'h3)[*2] |-> !test_wake; endproperty
  a_msk: assert property (p_msk) else $error("mask");
  c_tm: cover property (int_pending && int_vector == 16'h0024);
  c_nmi: cover property (nmi_pending);
  c_wake: cover property (test_wake);
endmodule
`default_nettype wire

// file: intc_regs.vh
// Constants for the interrupt and test input logic
`ifndef INTC_REGS_VH
`define INTC_REGS_VH
// ==========================================
// Sources and vectors
`define INTC_NSRC 19
`define INTC_IDX_W 5
`define INTC_PRIO_TM_A 5'h10
`define INTC_PRIO_TM_B 5'h11
`define INTC_PRIO_AD 5'h12
`define INTC_VEC_NMI 16'h0004
`define INTC_VEC_BASE 16'h0004
`define INTC_VEC_BRK 16'h003E
`define INTC_PORT_W 8
`endif

// file: interrupt_and_test_input_logic.v
// Interrupt request arbitration and test input flags
// Behaviour
// - Timer A match raises maskable request, priority 16, vector 0024H.
// - Timer B match raises maskable request, priority 17, vector 0026H.
// - Conversion done raises maskable request, priority 18, vector 0028H.
// - Break instruction takes software interrupt, no priority, vector 003EH.
// - Simultaneous maskable requests resolve by priority flag level first, then by default priority, 0 highest.
// - Per source request, mask, priority flags; global enable and in-service flag.
// - Two test sources: watch timer overflow and port 4 pins.
// - Falling edge on any port 4 pin sets the external test flag.
// - Watchdog overflow in watchdog mode raises non-maskable request at 0004H.
// - Seven external pin edges raise priorities 1 to 7, vectors from 0006H.
`default_nettype none
`include "intc_regs.vh"
module interrupt_and_test_input_logic #(
  parameter NSRC = `INTC_NSRC,
  parameter PORT_W = `INTC_PORT_W
) (
  input wire clk,
  input wire reset_n,
  input wire watchdog_overflow_req,
  input wire watchdog_mode_sel,
  input wire [6:0] ext_pin_edge,
  input wire [15:8] periph_req,
  input wire timer8_a_match_req,
  input wire timer8_b_match_req,
  input wire conversion_done_req,
  input wire software_break_insn,
  input wire [NSRC-1:0] mask_flag,
  input wire [NSRC-1:0] priority_select_flag,
  input wire [NSRC-1:0] req_clear,
  input wire global_enable_flag,
  input wire [1:0] test_mask_flag,
  input wire [1:0] test_clear,
  input wire watch_overflow_test,
  input wire [PORT_W-1:0] port4_pins,
  input wire ack,
  output reg [NSRC-1:0] request_flag,
  output reg in_service_level_flag,
  output reg int_pending,
  output reg [15:0] int_vector,
  output reg nmi_pending,
  output reg [1:0] test_flag,
  output reg test_wake
);
  // ==========================================
  // Internal nets and state
  localparam IDX_W = `INTC_IDX_W;
  wire port_fall_test;
  wire [NSRC-1:0] set_vec;
  wire [NSRC-1:0] elig_high;
  wire [NSRC-1:0] elig_low;
  reg [NSRC-1:0] pend_onehot;
  reg [IDX_W-1:0] high_idx;
  reg high_found;
  reg [IDX_W-1:0] low_idx;
  reg low_found;
  reg [IDX_W-1:0] win_idx;
  reg win_level;
  reg win_found;
  reg [IDX_W-1:0] pend_idx;
  reg pend_level;
  reg win_break;
  reg next_int_pending;
  reg [15:0] next_int_vector;
  reg next_win_break;
  reg [IDX_W-1:0] next_pend_idx;
  reg next_pend_level;
  reg next_in_service_level_flag;
  reg next_nmi_pending;
  reg [1:0] next_test_flag;
  reg next_test_wake;
  integer i;
  integer j;
  integer k;
  // ==========================================
  // Port falling edge
  // Pins are asynchronous; the detector synchronises them first
  edge_fall_detect #(.WIDTH(PORT_W)) u_fall (
    .clk(clk),
    .reset_n(reset_n),
    .pins(port4_pins),
    .fall(port_fall_test)
  );
  // ==========================================
  // Request sources; index equals default priority
  assign set_vec[0] = watchdog_overflow_req & ~watchdog_mode_sel;
  assign set_vec[7:1] = ext_pin_edge;
  assign set_vec[15:8] = periph_req;
  assign set_vec[16] = timer8_a_match_req;
  assign set_vec[17] = timer8_b_match_req;
  assign set_vec[18] = conversion_done_req;
  // ==========================================
  // Per source flags, set wins over clear
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_src
      assign elig_high[g] = request_flag[g] & ~mask_flag[g] & ~priority_select_flag[g];
      assign elig_low[g] = request_flag[g] & ~mask_flag[g] & priority_select_flag[g];
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          request_flag[g] <= 1'b0;
        end else if (set_vec[g]) begin
          request_flag[g] <= 1'b1;
        end else if (req_clear[g] || (ack && int_pending && !win_break && pend_onehot[g])) begin
          request_flag[g] <= 1'b0;
        end
      end
    end
  endgenerate
  // ==========================================
  // Source shown to the core
  // Clear by the registered index, not the live winner, which may move
  always @* begin
    pend_onehot = {NSRC{1'b0}};
    for (i = 0; i < NSRC; i = i + 1) begin
      if (pend_idx == i[IDX_W-1:0]) begin
        pend_onehot[i] = 1'b1;
      end
    end
  end
  // ==========================================
  // High level group, lowest index wins
  always @* begin
    high_found = 1'b0;
    high_idx = {IDX_W{1'b0}};
    for (j = NSRC - 1; j >= 0; j = j - 1) begin
      if (elig_high[j]) begin
        high_found = 1'b1;
        high_idx = j[IDX_W-1:0];
      end
    end
  end
  // ==========================================
  // Low level group, lowest index wins
  always @* begin
    low_found = 1'b0;
    low_idx = {IDX_W{1'b0}};
    for (k = NSRC - 1; k >= 0; k = k - 1) begin
      if (elig_low[k]) begin
        low_found = 1'b1;
        low_idx = k[IDX_W-1:0];
      end
    end
  end
  // ==========================================
  // Winner; high level group first
  always @* begin
    if (high_found) begin
      win_idx = high_idx;
      win_level = 1'b1;
    end else begin
      win_idx = low_idx;
      win_level = 1'b0;
    end
    // One level flag only, so high level service holds off every maskable request
    win_found = global_enable_flag && in_service_level_flag && (high_found || low_found);
  end
  // ==========================================
  // Non-maskable request, held until the core acknowledges
  always @* begin
    next_nmi_pending = nmi_pending;
    if (watchdog_overflow_req && watchdog_mode_sel) begin
      next_nmi_pending = 1'b1;
    end else if (ack && nmi_pending) begin
      next_nmi_pending = 1'b0;
    end
  end
  // ==========================================
  // Maskable and break request to the core
  // Break freezes the vector until acked, so a later maskable cannot hide it
  always @* begin
    next_int_pending = int_pending;
    next_int_vector = int_vector;
    next_win_break = win_break;
    next_pend_idx = pend_idx;
    next_pend_level = pend_level;
    next_in_service_level_flag = in_service_level_flag;
    if (software_break_insn) begin
      next_int_pending = 1'b1;
      next_win_break = 1'b1;
      next_int_vector = `INTC_VEC_BRK;
    end else if (ack && int_pending) begin
      next_int_pending = 1'b0;
      next_win_break = 1'b0;
      if (!win_break) begin
        next_in_service_level_flag = ~pend_level;
      end
    end else if (!win_break) begin
      next_int_pending = win_found;
      next_int_vector = `INTC_VEC_BASE + {{(15 - IDX_W){1'b0}}, win_idx, 1'b0};
      next_pend_idx = win_idx;
      next_pend_level = win_level;
    end
  end
  // ==========================================
  // Core side registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_pending <= 1'b0;
      int_vector <= 16'h0000;
      nmi_pending <= 1'b0;
      win_break <= 1'b0;
      pend_idx <= {IDX_W{1'b0}};
      pend_level <= 1'b0;
      in_service_level_flag <= 1'b1;
    end else begin
      int_pending <= next_int_pending;
      int_vector <= next_int_vector;
      nmi_pending <= next_nmi_pending;
      win_break <= next_win_break;
      pend_idx <= next_pend_idx;
      pend_level <= next_pend_level;
      in_service_level_flag <= next_in_service_level_flag;
    end
  end
  // ==========================================
  // Test flags; mask keeps flag from reaching the core
  always @* begin
    next_test_flag[0] = watch_overflow_test | (test_flag[0] & ~test_clear[0]);
    next_test_flag[1] = port_fall_test | (test_flag[1] & ~test_clear[1]);
    next_test_wake = |(test_flag & ~test_mask_flag);
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      test_flag <= 2'b00;
      test_wake <= 1'b0;
    end else begin
      test_flag <= next_test_flag;
      test_wake <= next_test_wake;
    end
  end
endmodule
`default_nettype wire

// file: tb_interrupt_and_test_input_logic.sv
// Self-checking bench for the interrupt and test input logic
`default_nettype none
module tb_interrupt_and_test_input_logic;
  timeunit 1ns;
  timeprecision 1ns;
  localparam NSRC = 19;
  logic clk = '0, reset_n = '0, watchdog_overflow_req = '0, watchdog_mode_sel = '1, ack, test_wake;
  logic timer8_a_match_req = '0, timer8_b_match_req = '0, conversion_done_req = '0, software_break_insn = '0;
  logic global_enable_flag = '1, watch_overflow_test = '0, in_service_level_flag, int_pending, nmi_pending;
  logic [6:0] ext_pin_edge = '0;
  logic [15:8] periph_req = '0;
  logic [18:0] mask_flag = '0, priority_select_flag = '1, req_clear = '0, request_flag;
  logic [1:0] test_mask_flag = '0, test_clear = '0, test_flag;
  logic [7:0] port4_pins = '1;
  logic [15:0] int_vector;
  int mismatches = 0, num_checks = 0;
  interrupt_and_test_input_logic interrupt_and_test_input_logic_i (.*);
  core_ack_model core_ack_model_i (.*);
  initial forever #20 clk = ~clk;
  task chk(input logic c);
    num_checks++;
    if (c !== 1'h1) begin
      mismatches++;
      $display("[ERR] %0t wrong result", $time);
    end
  endtask
  // Vector is read while the core model acks it
  task want(input logic [15:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk) #1;
      n++;
    end while (n < 20 && ack !== 1'h1);
    chk(ack === 1'h1 && int_vector === v);
  endtask
  task t_prio;
    @(posedge clk) {timer8_a_match_req, timer8_b_match_req, conversion_done_req} <= 3'h7;
    @(posedge clk) {timer8_a_match_req, timer8_b_match_req, conversion_done_req} <= 3'h0;
    want(16'h0024);
    want(16'h0026);
    want(16'h0028);
  endtask
  task t_ext;
    @(posedge clk) global_enable_flag <= 1'h0;
    ext_pin_edge <= 7'h01;
    @(posedge clk) ext_pin_edge <= 7'h00;
    repeat (3) @(posedge clk);
    #1 chk(int_pending === 1'h0 && request_flag[1] === 1'h1 && in_service_level_flag === 1'h1);
    @(posedge clk) global_enable_flag <= 1'h1;
    want(16'h0006);
  endtask
  task t_brk;
    @(posedge clk) global_enable_flag <= 1'h0;
    software_break_insn <= 1'h1;
    @(posedge clk) software_break_insn <= 1'h0;
    want(16'h003E);
    @(posedge clk) watchdog_overflow_req <= 1'h1;
    @(posedge clk) watchdog_overflow_req <= 1'h0;
    #1 chk(nmi_pending === 1'h1);
  endtask
  task t_test;
    @(posedge clk) test_mask_flag <= 2'h2;
    port4_pins <= 8'hFB;
    repeat (6) @(posedge clk);
    #1 chk(test_flag === 2'h2 && test_wake === 1'h0);
    @(posedge clk) watch_overflow_test <= 1'h1;
    @(posedge clk) watch_overflow_test <= 1'h0;
    @(posedge clk) #1 chk(test_flag[0] === 1'h1 && test_wake === 1'h1);
    @(posedge clk) test_mask_flag <= 2'h3;
    repeat (2) @(posedge clk);
    #1 chk(test_wake === 1'h0);
  endtask
  // High level request, timer B masked; its service then clears the level flag
  task t_lvl;
    @(posedge clk) global_enable_flag <= 1'h1;
    priority_select_flag[16] <= 1'h0;
    mask_flag[17] <= 1'h1;
    {timer8_a_match_req, timer8_b_match_req} <= 2'h3;
    @(posedge clk) {timer8_a_match_req, timer8_b_match_req} <= 2'h0;
    want(16'h0024);
    @(posedge clk) #1 chk(in_service_level_flag === 1'h0 && request_flag[17] === 1'h1 && int_pending === 1'h0);
  endtask
  task close_out;
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    t_prio;
    t_ext;
    t_brk;
    t_test;
    t_lvl;
    close_out;
  end
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
endmodule
bind interrupt_and_test_input_logic intc_checker intc_checker_i (.*);
`default_nettype wire
